// ### pcs_core.sv
// Purpose: program counter, circular return stack and indirect addressing
// Assumes: decoder gives one flow op per cycle; data memory is external
// Notes: stack pointer and stack state are invisible to software
//
// Summary of operation
// - program counter is 13 bits and addresses program memory
// - low program counter byte is a readable and writable data register
// - software loads upper five bits only through the upper holding register
// - any reset clears the whole program counter
// - writing the low byte copies holding bits 4..0 into upper bits
// - call or goto takes top two bits from holding bits 4..3
// - eight-entry 13-bit return stack outside program and data spaces
// - stack pointer cannot be read or written by software
// - call pushes the program counter plus one; interrupt vectoring pushes the program counter
// - return, return with literal, return from interrupt pop the stack
// - pushes and pops leave the upper holding register untouched
// - stack wraps circularly; ninth push overwrites the first entry
// - no overflow or underflow indication exists
// - indirect location has no storage; accesses go via file pointer
// - indirect read of the indirect location itself returns zero
// - indirect write of the indirect location itself stores nothing
// - indirect address is bank bit above the 8-bit file pointer
`timescale 1ns/1ps
module pcs_core (
   input wire logic CLK_IN, // core clock
   input wire logic RESET_IN, // sync reset, active high
   input wire pcs_pkg::pcs_flow_s FLOW_IN, // flow op from decoder
   input wire logic PC_LOW_WR_IN, // write of pc_low_byte
   input wire logic HOLD_WR_IN, // write of pc_upper_holding
   input wire logic FP_WR_IN, // write of file_pointer
   input wire logic [7:0] WDATA_IN, // register write data
   input wire pcs_pkg::pcs_dacc_s DACC_IN, // data access from core
   input wire logic [7:0] MEM_RDATA_IN, // data memory read data
   output logic [12:0] PC_OUT, // program fetch address
   output logic [7:0] PC_LOW_OUT, // pc_low_byte read value
   output logic [4:0] HOLD_OUT, // pc_upper_holding read value
   output logic [7:0] FP_OUT, // file_pointer read value
   output logic [8:0] MEM_ADDR_OUT, // effective data address
   output logic MEM_RD_OUT, // data memory read strobe
   output logic MEM_WR_OUT, // data memory write strobe
   output logic [7:0] MEM_WDATA_OUT, // data memory write data
   output logic [7:0] RDATA_OUT // data read value to core
);
   import pcs_pkg::*;

   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [HI_W-1:0] hold_r;
   logic [DATA_W-1:0] fp_r;
   logic [SP_W-1:0] sp_r;
   logic [PC_W-1:0] stack_r [STK_DEPTH];
   logic push;
   logic pop;
   logic [SP_W-1:0] top_idx;
   logic is_ind;
   logic ind_self;
   logic [DADDR_W-1:0] eff_addr;

   assign push = (FLOW_IN.op == PCS_OP_CALL) ||
                 (FLOW_IN.op == PCS_OP_VECTOR);
   assign pop = (FLOW_IN.op == PCS_OP_RET);
   assign top_idx = sp_r - SP_ONE;

   // pc write has priority over flow op: it is the executing instruction
   always_comb begin
      case (FLOW_IN.op)
         PCS_OP_NEXT: pc_nxt = pc_r + PC_ONE;
         PCS_OP_JUMP, PCS_OP_CALL: begin
            pc_nxt = {hold_r[HI_W-1:HOLD_JMP_LSB], FLOW_IN.target};
         end
         PCS_OP_RET: pc_nxt = stack_r[top_idx];
         PCS_OP_VECTOR: pc_nxt = FLOW_IN.vector;
         PCS_OP_HOLD: pc_nxt = pc_r;
         default: pc_nxt = pc_r;
      endcase
      if (PC_LOW_WR_IN) begin
         pc_nxt = {hold_r, WDATA_IN};
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         pc_r <= PC_RST;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   // holding register only changes on its own write
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         hold_r <= HOLD_RST;
      end else if (HOLD_WR_IN) begin
         hold_r <= WDATA_IN[HI_W-1:0];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         fp_r <= FP_RST;
      end else if (FP_WR_IN) begin
         fp_r <= WDATA_IN;
      end
   end

   // pointer wraps freely; no flags by design
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         sp_r <= SP_RST;
      end else if (push) begin
         sp_r <= sp_r + SP_ONE;
      end else if (pop) begin
         sp_r <= sp_r - SP_ONE;
      end
   end

   // entries need no reset; stale reads are allowed
   always_ff @(posedge CLK_IN) begin
      if (push) begin
         if (FLOW_IN.op == PCS_OP_CALL) begin
            stack_r[sp_r] <= pc_r + PC_ONE;
         end else begin
            stack_r[sp_r] <= pc_r;
         end
      end
   end

   assign is_ind = ((DACC_IN.addr & LOC_MASK) == INDIRECT_LOC);
   // pointer aimed at any bank's copy of the indirect location
   assign ind_self = is_ind && ((fp_r & LOC_MASK) == INDIRECT_LOC);
   assign eff_addr = is_ind ? {DACC_IN.bank, fp_r}
                            : {DACC_IN.bank, DACC_IN.addr};

   always_comb begin
      MEM_ADDR_OUT = eff_addr;
      MEM_RD_OUT = DACC_IN.rd && !ind_self;
      MEM_WR_OUT = DACC_IN.wr && !ind_self;
      MEM_WDATA_OUT = DACC_IN.wdata;
      RDATA_OUT = ind_self ? ZERO_BYTE : MEM_RDATA_IN;
   end

   assign PC_OUT = pc_r;
   assign PC_LOW_OUT = pc_r[LOW_W-1:0];
   assign HOLD_OUT = hold_r;
   assign FP_OUT = fp_r;

   a_reset_clears_pc: assert property (@(posedge CLK_IN)
      RESET_IN |=> pc_r == PC_RST)
      else $error("pc not cleared by reset");
   a_low_write_load: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      PC_LOW_WR_IN |=> pc_r == {$past(hold_r), $past(WDATA_IN)})
      else $error("pc low write load wrong");
   a_jump_upper_bits: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op inside {PCS_OP_JUMP, PCS_OP_CALL})
      |=> pc_r[PC_W-1:JMP_W] == $past(hold_r[HI_W-1:HOLD_JMP_LSB]))
      else $error("jump upper bits wrong");
   a_call_ret_pair: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (FLOW_IN.op == PCS_OP_CALL && !PC_LOW_WR_IN) ##1
      (FLOW_IN.op == PCS_OP_RET && !PC_LOW_WR_IN)
      |=> pc_r == $past(pc_r, 2) + PC_ONE)
      else $error("call return pair wrong");
   a_hold_stable_stack: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      ((push || pop) && !HOLD_WR_IN) |=> $stable(hold_r))
      else $error("holding changed by stack");
   a_sp_wraps: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      push |=> sp_r == $past(sp_r) + SP_ONE)
      else $error("stack pointer wrong after push");
   a_pop_decrements: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (pop && !push) |=> sp_r == $past(sp_r) - SP_ONE)
      else $error("stack pointer wrong after pop");
   a_self_read_zero: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (ind_self && DACC_IN.rd) |-> RDATA_OUT == ZERO_BYTE)
      else $error("self indirect read not zero");
   a_self_write_drop: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      ind_self |-> !MEM_WR_OUT)
      else $error("self indirect write stored");
   a_indirect_addr: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      is_ind |-> MEM_ADDR_OUT == {DACC_IN.bank, fp_r})
      else $error("indirect address wrong");

   a_next_incr: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op == PCS_OP_NEXT)
      |=> pc_r == $past(pc_r) + PC_ONE)
      else $error("pc did not advance");

   a_hold_keeps_pc: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op == PCS_OP_HOLD)
      |=> $stable(pc_r))
      else $error("pc moved during hold");

   a_jump_low_bits: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op inside {PCS_OP_JUMP, PCS_OP_CALL})
      |=> pc_r[JMP_W-1:0] == $past(FLOW_IN.target))
      else $error("jump low bits wrong");

   a_vector_load: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op == PCS_OP_VECTOR)
      |=> pc_r == $past(FLOW_IN.vector))
      else $error("vector not loaded");

   a_call_entry: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      FLOW_IN.op == PCS_OP_CALL
      |=> stack_r[$past(sp_r)] == $past(pc_r) + PC_ONE)
      else $error("call pushed wrong address");

   a_vector_entry: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      FLOW_IN.op == PCS_OP_VECTOR
      |=> stack_r[$past(sp_r)] == $past(pc_r))
      else $error("vector pushed wrong address");

   a_ret_pop_value: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op == PCS_OP_RET)
      |=> pc_r == stack_r[sp_r])
      else $error("return took wrong entry");

   a_low_write_byte: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      PC_LOW_WR_IN
      |=> PC_LOW_OUT == $past(WDATA_IN))
      else $error("low byte write lost");

   a_upper_no_carry: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!PC_LOW_WR_IN && FLOW_IN.op == PCS_OP_NEXT &&
       pc_r[LOW_W-1:0] != {LOW_W{1'b1}}) |=> $stable(pc_r[PC_W-1:LOW_W]))
      else $error("upper bits changed without source");

   a_hold_load: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      HOLD_WR_IN
      |=> hold_r == $past(WDATA_IN[HI_W-1:0]))
      else $error("holding write lost");

   a_hold_keep: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      !HOLD_WR_IN
      |=> $stable(hold_r))
      else $error("holding changed unasked");

   a_fp_load: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      FP_WR_IN
      |=> fp_r == $past(WDATA_IN))
      else $error("pointer write lost");

   a_fp_keep: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      !FP_WR_IN
      |=> $stable(fp_r))
      else $error("pointer changed unasked");

   a_sp_idle: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      (!push && !pop)
      |=> $stable(sp_r))
      else $error("stack pointer moved unasked");

   a_direct_addr: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      !is_ind
      |-> MEM_ADDR_OUT == {DACC_IN.bank, DACC_IN.addr})
      else $error("direct address wrong");

   a_read_strobe: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      !ind_self
      |-> MEM_RD_OUT == DACC_IN.rd)
      else $error("read strobe wrong");

   a_self_read_quiet: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      ind_self
      |-> !MEM_RD_OUT)
      else $error("self indirect read reached memory");

   a_read_pass: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      !ind_self
      |-> RDATA_OUT == MEM_RDATA_IN)
      else $error("read data not passed");

   a_wdata_pass: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      DACC_IN.wr
      |-> MEM_WDATA_OUT == DACC_IN.wdata)
      else $error("write data not passed");

   a_write_strobe: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      !ind_self
      |-> MEM_WR_OUT == DACC_IN.wr)
      else $error("write strobe wrong");

   a_reset_clears_regs: assert property (@(posedge CLK_IN)
      RESET_IN
      |=> hold_r == HOLD_RST && fp_r == FP_RST && sp_r == SP_RST)
      else $error("registers not cleared by reset");


   c_call_ret: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
      FLOW_IN.op == PCS_OP_CALL ##[1:20] FLOW_IN.op == PCS_OP_RET);
   c_nine_push: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && sp_r == SP_RST && stack_r[SP_RST] != PC_RST);
   c_self_ind: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
      ind_self && DACC_IN.wr);
   c_vector_push: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
      push && FLOW_IN.op == PCS_OP_VECTOR);
   c_low_write: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
      PC_LOW_WR_IN && FLOW_IN.op == PCS_OP_HOLD);
endmodule : pcs_core

// ### pcs_mem_model.sv
// Purpose: data memory seen through the effective address port
// Assumes: writes land on the rising edge, reads are combinational
// Notes: an unstrobed read shows a toggling pattern, never the last data
`timescale 1ns/1ps
module pcs_mem_model (
   input wire logic clk_in, // core clock
   input wire logic [8:0] addr_in, // effective data address
   input wire logic rd_in, // read strobe
   input wire logic wr_in, // write strobe
   input wire logic [7:0] wdata_in, // write data
   output logic [7:0] rdata_out // read data
);
   logic [7:0] mem [512];
   logic [7:0] idle_r = 8'hA5;
   always_ff @(posedge clk_in) begin
      if (wr_in) begin
         mem[addr_in] <= wdata_in;
      end
      idle_r <= ~idle_r;
   end
   // released bus changes every cycle so a missed strobe cannot match
   assign rdata_out = rd_in ? mem[addr_in] : idle_r;
endmodule : pcs_mem_model

// ### pcs_pkg.sv
// Purpose: shared constants and carriers for program counter, stack and
//          indirect addressing logic
// Assumes: one core clock, synchronous active-high reset
// Notes: data addresses are 9 bits, bank bit on top
package pcs_pkg;
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int HI_W = 5;
   localparam int JMP_W = 11;
   localparam int HOLD_JMP_LSB = 3;
   localparam int STK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int DADDR_W = 9;
   localparam int DATA_W = 8;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [HI_W-1:0] HOLD_RST = 5'h00;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam logic [SP_W-1:0] SP_ONE = 3'h1;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   localparam logic [DATA_W-1:0] FP_RST = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   // direct data address (low 7 bits) of the indirect access location
   localparam logic [DATA_W-1:0] INDIRECT_LOC = 8'h00;
   localparam logic [DATA_W-1:0] LOC_MASK = 8'h7F;

   typedef enum logic [2:0] {
      PCS_OP_NEXT,
      PCS_OP_JUMP,
      PCS_OP_CALL,
      PCS_OP_RET,
      PCS_OP_VECTOR,
      PCS_OP_HOLD
   } pcs_op_e;

   typedef struct packed {
      pcs_op_e op;
      logic [JMP_W-1:0] target;
      logic [PC_W-1:0] vector;
   } pcs_flow_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [DATA_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic bank;
   } pcs_dacc_s;
endpackage : pcs_pkg

// ### testbench.sv
// Purpose: random and directed checks of pc, stack and indirect access
// Assumes: inputs change on the falling edge or 1 ns after it
// Notes: reference model tracks pc, holding, pointer and stack
`timescale 1ns/1ps
module testbench;
   import pcs_pkg::*;
   logic clk = 1'b0, rst = 1'b1, pw = 1'b0, hw = 1'b0, fw = 1'b0;
   logic [7:0] wd = 8'h00, mrd, plow, fpo, mwd, rdata, e_fp, f;
   pcs_flow_s flow = '0;
   pcs_dacc_s dacc = '0;
   logic [12:0] pc, e_pc, stk [8];
   logic [4:0] hold, e_hold;
   logic [8:0] maddr;
   logic m_rd, mwr;
   logic [2:0] sp, k;
   logic [15:0] rnd = 16'h83E9;
   int errors = 0, n_compared = 0;
   pcs_core u_pcs_core (.CLK_IN(clk), .RESET_IN(rst), .FLOW_IN(flow),
      .PC_LOW_WR_IN(pw), .HOLD_WR_IN(hw), .FP_WR_IN(fw), .WDATA_IN(wd),
      .DACC_IN(dacc), .MEM_RDATA_IN(mrd), .PC_OUT(pc), .PC_LOW_OUT(plow),
      .HOLD_OUT(hold), .FP_OUT(fpo), .MEM_ADDR_OUT(maddr),
      .MEM_RD_OUT(m_rd), .MEM_WR_OUT(mwr), .MEM_WDATA_OUT(mwd),
      .RDATA_OUT(rdata));
   pcs_mem_model u_pcs_mem_model (.clk_in(clk), .addr_in(maddr),
      .rd_in(m_rd), .wr_in(mwr), .wdata_in(mwd), .rdata_out(mrd));
   initial forever #2 clk = ~clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input logic [12:0] got, exp, input string w);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic step(input pcs_op_e op, input logic [10:0] tg,
      input logic [12:0] v, input logic p, h, fp, input logic [7:0] d);
      flow = '{op, tg, v};
      {pw, hw, fw, wd} = {p, h, fp, d};
      @(negedge clk);
      if (p) e_pc = {e_hold, d};
      else if (op == PCS_OP_NEXT) e_pc = e_pc + 13'h0001;
      else if (op == PCS_OP_JUMP || op == PCS_OP_CALL) begin
         if (op == PCS_OP_CALL) stk[sp++] = e_pc + 13'h0001;
         e_pc = {e_hold[4:3], tg};
      end else if (op == PCS_OP_VECTOR) begin
         stk[sp++] = e_pc;
         e_pc = v;
      end else if (op == PCS_OP_RET) e_pc = stk[--sp];
      if (h) e_hold = d[4:0];
      if (fp) e_fp = d;
      chk(pc, e_pc, "pc");
      chk(13'(plow), 13'(e_pc[7:0]), "low");
      chk(13'(hold), 13'(e_hold), "hold");
      chk(13'(fpo), 13'(e_fp), "fp");
   endtask : step
   task automatic rst_chk();
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      {e_pc, e_hold, e_fp, sp} = '0;
      chk(pc, 13'h0000, "reset");
   endtask : rst_chk
   initial begin
      #8000;
      errors++;
      final_report();
   end
   initial begin
      rst_chk();
      step(PCS_OP_HOLD, 11'h000, 13'h0000, 1'b0, 1'b1, 1'b0, 8'h18);
      step(PCS_OP_CALL, 11'h123, 13'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      chk(pc, 13'h1923, "call");
      step(PCS_OP_RET, 11'h000, 13'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      for (int i = 0; i < 9; i++)
         step(PCS_OP_CALL, 11'(i * 37), 13'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      for (int i = 0; i < 10; i++)
         step(PCS_OP_RET, 11'h000, 13'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      for (int i = 0; i < 200; i++) begin
         rnd = lfsr(rnd);
         k = rnd[15:13];
         // pc low writes may cross 256-word blocks freely
         if (k > 3'h5) step(PCS_OP_HOLD, 11'h000, 13'h0000, k[0], ~k[0], 1'b0, rnd[7:0]);
         else step(pcs_op_e'(k), rnd[10:0], rnd[12:0], 1'b0, 1'b0, 1'b0, 8'h00);
      end
      rst_chk();
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         f = (i > 4) ? {rnd[7], 7'h00} : rnd[7:0] | 8'h01;
         step(PCS_OP_HOLD, 11'h000, 13'h0000, 1'b0, 1'b0, 1'b1, f);
         dacc = '{1'b0, 1'b1, 8'h00, rnd[15:8], rnd[8]};
         #1;
         chk(13'(maddr), 13'({rnd[8], f}), "addr");
         chk(13'(mwr), 13'(i < 5), "wr");
         @(negedge clk);
         dacc = '{1'b1, 1'b0, 8'h80, 8'h00, rnd[8]};
         #1;
         chk(13'(rdata), (i < 5) ? 13'(rnd[15:8]) : 13'h0000, "rd");
         dacc = '0;
      end
      final_report();
   end
endmodule : testbench
